//--- inc/word_input_link.sv
// link between the computer's input channel and the external word source
`timescale 1ns/1ns
`default_nettype none

interface word_input_link;

   // computer to external equipment
   logic in_wait;
   logic in_strobe;
   logic in_term_n;
   logic skip_strobe;
   // external equipment to computer
   logic external_ready_n;
   logic [0:word_input_pkg::WORD_W-1] input_data_line_n;
   logic unit_resp_n;
   logic system_resp_n;

   modport dev
   (
      output in_wait,
      output in_strobe,
      output in_term_n,
      output skip_strobe,
      input external_ready_n,
      input input_data_line_n,
      input unit_resp_n,
      input system_resp_n
   );

   modport ext
   (
      input in_wait,
      input in_strobe,
      input in_term_n,
      input skip_strobe,
      output external_ready_n,
      output input_data_line_n,
      output unit_resp_n,
      output system_resp_n
   );

endinterface : word_input_link

`default_nettype wire

//--- inc/word_input_pkg.sv
// shared constants and helpers for the parallel word input link
package word_input_pkg;

   // word and buffer geometry
   localparam int WORD_W = 24;
   localparam int FIFO_DEPTH = 32;

   // timing: one computer cycle is a whole number of system clocks
   localparam int CLK_PERIOD_NS = 100;
   localparam int CYCLE_NS = 800;
   localparam int CYCLE_CLKS = CYCLE_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CYCLE_LAST = CNT_W'(CYCLE_CLKS - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

   // wait-phase cycle counter
   localparam int WAIT_CNT_W = 16;
   localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_ZERO = 16'h0000;
   localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_ONE = 16'h0001;
   localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_MAX = 16'hFFFF;

   // link line levels: lines are true at zero volts
   localparam logic LINE_TRUE = 1'b0;
   localparam logic LINE_FALSE = 1'b1;
   localparam logic [0:WORD_W-1] WORD_LINES_IDLE = 24'hFFFFFF;
   localparam logic [0:WORD_W-1] WORD_ZERO = 24'h000000;

   // which response line a skip-test instruction interrogates
   typedef enum logic
   {
      SKIP_UNIT_TEST = 1'b0,
      SKIP_SYSTEM = 1'b1
   } skip_mode_t;

   // data lines carry the inverse of the word, bit i on line i
   function automatic logic [0:WORD_W-1] word_to_lines
   (
      input logic [0:WORD_W-1] v
   );
      return ~v;
   endfunction : word_to_lines

   function automatic logic [0:WORD_W-1] lines_to_word
   (
      input logic [0:WORD_W-1] v
   );
      return ~v;
   endfunction : lines_to_word

endpackage : word_input_pkg

//--- rtl/word_input_channel.sv
// computer end of the parallel word input connector
`timescale 1ns/1ns
`default_nettype none

// Contract
// R01 - strobe every computer cycle while input waits
// R02 - signal termination when input instruction finishes
// R03 - one skip-test strobe per skip-test instruction
// R04 - skip when unit-test response line is low
// R05 - skip on low system line, not high
// R06 - external equipment drives ready low to transfer
// R07 - load data lines into C register, bitwise
// R08 - data lines active low, inverted on load
// R09 - leave wait phase once ready goes low
// R10 - external data held from ready until termination
module word_input_channel
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // instruction requests from the sequencer
   input wire logic i_input_start,
   input wire logic i_skip_start,
   input wire logic i_skip_mode,
   // results toward the sequencer
   output logic o_busy,
   output logic [0:word_input_pkg::WORD_W-1] o_c_word,
   output logic o_word_valid,
   output logic o_skip_done,
   output logic o_skip_taken,
   output logic [word_input_pkg::WAIT_CNT_W-1:0] o_wait_cycles,
   // link toward the external equipment
   word_input_link.dev link
);

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_TERM = 4'h4,
      ST_SKIP = 4'h8
   } dev_state_t;

   typedef struct packed
   {
      dev_state_t st;
      logic [word_input_pkg::CNT_W-1:0] cyc;
      logic [0:word_input_pkg::WORD_W-1] c_reg;
      logic in_strobe;
      logic in_term_n;
      logic skip_strobe;
      logic skip_mode;
      logic word_valid;
      logic skip_done;
      logic skip_taken;
      logic [word_input_pkg::WAIT_CNT_W-1:0] wait_cycles;
   } dev_regs_t;

   dev_regs_t r_q;
   dev_regs_t r_d;
   logic cycle_en;
   logic resp_true;

   // link lines are true at zero volts
   function automatic logic line_true
   (
      input logic v
   );
      return (v == word_input_pkg::LINE_TRUE);
   endfunction : line_true

   // one-cycle enable marks the last clock of each computer cycle
   assign cycle_en = (r_q.cyc == word_input_pkg::CYCLE_LAST);

   // response line of the interrogated kind, true at zero volts
   always_comb
   begin
      if (r_q.skip_mode == word_input_pkg::SKIP_SYSTEM)
      begin
         resp_true = line_true(link.system_resp_n); // [R05]
      end
      else
      begin
         resp_true = line_true(link.unit_resp_n); // [R04]
      end
   end

   always_comb
   begin
      r_d = r_q;
      r_d.in_strobe = 1'b0;
      r_d.skip_strobe = 1'b0;
      r_d.word_valid = 1'b0;
      r_d.skip_done = 1'b0;
      r_d.skip_taken = 1'b0;
      if (cycle_en)
      begin
         r_d.cyc = word_input_pkg::CNT_ZERO;
      end
      else
      begin
         r_d.cyc = r_q.cyc + word_input_pkg::CNT_ONE;
      end

      unique case (r_q.st)
         ST_IDLE:
         begin
            r_d.in_term_n = word_input_pkg::LINE_FALSE;
            // input has priority when both instructions arrive together
            if (i_input_start)
            begin
               r_d.st = ST_WAIT;
               r_d.wait_cycles = word_input_pkg::WAIT_CNT_ZERO;
            end
            else if (i_skip_start)
            begin
               r_d.st = ST_SKIP;
               r_d.skip_mode = i_skip_mode;
               r_d.skip_strobe = 1'b1; // [R03]
            end
         end
         ST_WAIT:
         begin
            if (cycle_en)
            begin
               // ready is only looked at once per computer cycle, so a
               // short glitch between cycle ends cannot release the wait
               if (line_true(link.external_ready_n)) // [R06]
               begin
                  // each line is inverted into the like-numbered C bit
                  r_d.c_reg = word_input_pkg::lines_to_word( // [R07] [R08]
                     link.input_data_line_n);
                  r_d.st = ST_TERM; // [R09]
                  r_d.in_term_n = word_input_pkg::LINE_TRUE; // [R02]
                  r_d.word_valid = 1'b1;
               end
               else
               begin
                  r_d.in_strobe = 1'b1; // [R01]
                  if (r_q.wait_cycles != word_input_pkg::WAIT_CNT_MAX)
                  begin
                     r_d.wait_cycles =
                        r_q.wait_cycles + word_input_pkg::WAIT_CNT_ONE;
                  end
               end
            end
         end
         ST_TERM:
         begin
            // termination stands for one whole computer cycle so that
            // equipment sampling at cycle rate cannot miss it
            if (cycle_en)
            begin
               r_d.in_term_n = word_input_pkg::LINE_FALSE; // [R02]
               r_d.st = ST_IDLE;
            end
         end
         ST_SKIP:
         begin
            // the response is sampled at the end of the instruction cycle
            if (cycle_en)
            begin
               r_d.skip_done = 1'b1;
               r_d.skip_taken = resp_true; // [R04] [R05]
               r_d.st = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         r_q.st <= ST_IDLE;
         r_q.cyc <= word_input_pkg::CNT_ZERO;
         r_q.c_reg <= word_input_pkg::WORD_ZERO;
         r_q.in_strobe <= 1'b0;
         r_q.in_term_n <= word_input_pkg::LINE_FALSE;
         r_q.skip_strobe <= 1'b0;
         r_q.skip_mode <= word_input_pkg::SKIP_UNIT_TEST;
         r_q.word_valid <= 1'b0;
         r_q.skip_done <= 1'b0;
         r_q.skip_taken <= 1'b0;
         r_q.wait_cycles <= word_input_pkg::WAIT_CNT_ZERO;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // link outputs
   assign link.in_wait = (r_q.st == ST_WAIT);
   assign link.in_strobe = r_q.in_strobe;
   assign link.in_term_n = r_q.in_term_n;
   assign link.skip_strobe = r_q.skip_strobe;

   // sequencer outputs
   // a start that arrives while busy is dropped without notice, so the
   // sequencer has to hold off until o_busy falls
   assign o_busy = (r_q.st != ST_IDLE);
   assign o_c_word = r_q.c_reg;
   assign o_word_valid = r_q.word_valid;
   assign o_skip_done = r_q.skip_done;
   assign o_skip_taken = r_q.skip_taken;
   assign o_wait_cycles = r_q.wait_cycles;

endmodule : word_input_channel

`default_nettype wire

//--- rtl/word_input_source.sv
// external equipment end: word buffer and input-channel coupling logic
`timescale 1ns/1ns
`default_nettype none

module word_source_fifo
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] PTR_STEP = (PTR_W+1)'(1);

   typedef struct packed
   {
      logic [PTR_W:0] wr;
      logic [PTR_W:0] rd;
   } fifo_regs_t;

   fifo_regs_t r_q;
   fifo_regs_t r_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign empty = (r_q.wr == r_q.rd);
   assign full = (r_q.wr[PTR_W] != r_q.rd[PTR_W]) &&
                 (r_q.wr[PTR_W-1:0] == r_q.rd[PTR_W-1:0]);
   assign push = i_in_valid && !full;
   assign pop = i_out_ready && !empty;
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[r_q.rd[PTR_W-1:0]];

   always_comb
   begin
      r_d = r_q;
      if (push)
      begin
         r_d.wr = r_q.wr + PTR_STEP;
      end
      if (pop)
      begin
         r_d.rd = r_q.rd + PTR_STEP;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         r_q <= '0;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[r_q.wr[PTR_W-1:0]] <= i_in_data;
      end
   end

endmodule : word_source_fifo

module word_input_source
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // words to send
   input wire logic i_word_valid,
   output logic o_word_ready,
   input wire logic [0:word_input_pkg::WORD_W-1] i_word,
   // unit conditions reported on skip tests
   input wire logic i_unit_condition,
   input wire logic i_system_condition,
   // status
   output logic o_word_sent,
   output logic o_skip_seen,
   // link toward the computer
   word_input_link.ext link
);

   typedef enum logic [1:0]
   {
      SRC_IDLE = 2'h1,
      SRC_HOLD = 2'h2
   } src_state_t;

   typedef struct packed
   {
      src_state_t st;
      logic ready_n;
      logic [0:word_input_pkg::WORD_W-1] lines_n;
      logic unit_n;
      logic system_n;
      logic word_sent;
      logic skip_seen;
   } src_regs_t;

   src_regs_t r_q;
   src_regs_t r_d;
   logic fifo_valid;
   logic fifo_pop;
   logic [0:word_input_pkg::WORD_W-1] fifo_word;

   // the buffer drains only when the computer asks, so it fills and
   // pushes back on the word producer
   word_source_fifo
   #(
      .WIDTH(word_input_pkg::WORD_W),
      .DEPTH(word_input_pkg::FIFO_DEPTH)
   )
   u_fifo
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_in_valid(i_word_valid),
      .o_in_ready(o_word_ready),
      .i_in_data(i_word),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_word)
   );

   assign fifo_pop = (r_q.st == SRC_IDLE) && link.in_wait && fifo_valid;

   always_comb
   begin
      r_d = r_q;
      r_d.word_sent = 1'b0;
      r_d.skip_seen = link.skip_strobe;
      r_d.unit_n = i_unit_condition ? word_input_pkg::LINE_TRUE
                                    : word_input_pkg::LINE_FALSE; // [R04]
      r_d.system_n = i_system_condition ? word_input_pkg::LINE_TRUE
                                        : word_input_pkg::LINE_FALSE; // [R05]
      unique case (r_q.st)
         SRC_IDLE:
         begin
            if (fifo_pop)
            begin
               r_d.lines_n = word_input_pkg::word_to_lines(fifo_word); // [R08]
               r_d.ready_n = word_input_pkg::LINE_TRUE; // [R06]
               r_d.st = SRC_HOLD;
            end
         end
         SRC_HOLD:
         begin
            // data and ready stand until termination is seen
            if (link.in_term_n == word_input_pkg::LINE_TRUE) // [R10]
            begin
               r_d.lines_n = word_input_pkg::WORD_LINES_IDLE;
               r_d.ready_n = word_input_pkg::LINE_FALSE;
               r_d.word_sent = 1'b1;
               r_d.st = SRC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         r_q.st <= SRC_IDLE;
         r_q.ready_n <= word_input_pkg::LINE_FALSE;
         r_q.lines_n <= word_input_pkg::WORD_LINES_IDLE;
         r_q.unit_n <= word_input_pkg::LINE_FALSE;
         r_q.system_n <= word_input_pkg::LINE_FALSE;
         r_q.word_sent <= 1'b0;
         r_q.skip_seen <= 1'b0;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign link.external_ready_n = r_q.ready_n;
   assign link.input_data_line_n = r_q.lines_n;
   assign link.unit_resp_n = r_q.unit_n;
   assign link.system_resp_n = r_q.system_n;
   assign o_word_sent = r_q.word_sent;
   assign o_skip_seen = r_q.skip_seen;

endmodule : word_input_source

`default_nettype wire

//--- verif/parallel_word_input_port_test.sv
// self-checking bench joining both ends of the word input link
`timescale 1ns/1ns
`default_nettype none
module parallel_word_input_port_test;
   logic i_clk, i_reset, in_start, sk_start, sk_mode, busy;
   logic w_valid, sk_done, sk_taken, wd_valid, wd_ready, unit_c, sys_c;
   logic w_sent, sk_seen;
   logic [0:word_input_pkg::WORD_W-1] c_word, wd;
   logic [word_input_pkg::WAIT_CNT_W-1:0] wait_cyc;
   int failures, checks_done, n_strobe, n_skip, n_sent, n_seen;
   // codes of the design outputs that a bounded wait can poll
   localparam int WATCH_READY = 0;
   localparam int WATCH_VALID = 1;
   localparam int WATCH_BUSY = 2;
   localparam int WATCH_SKIP = 3;
   word_input_link link();

   word_input_channel u_word_input_channel
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_input_start(in_start),
      .i_skip_start(sk_start),
      .i_skip_mode(sk_mode),
      .o_busy(busy),
      .o_c_word(c_word),
      .o_word_valid(w_valid),
      .o_skip_done(sk_done),
      .o_skip_taken(sk_taken),
      .o_wait_cycles(wait_cyc),
      .link(link.dev)
   );
   word_input_source u_word_input_source
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_word_valid(wd_valid),
      .o_word_ready(wd_ready),
      .i_word(wd),
      .i_unit_condition(unit_c),
      .i_system_condition(sys_c),
      .o_word_sent(w_sent),
      .o_skip_seen(sk_seen),
      .link(link.ext)
   );
   word_input_link_assertions u_word_input_link_assertions
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .in_wait(link.in_wait),
      .in_strobe(link.in_strobe),
      .in_term_n(link.in_term_n),
      .skip_strobe(link.skip_strobe),
      .external_ready_n(link.external_ready_n),
      .input_data_line_n(link.input_data_line_n),
      .unit_resp_n(link.unit_resp_n),
      .system_resp_n(link.system_resp_n)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // strobes are counted at the edge, before that edge's updates land
   always @(posedge i_clk)
   begin
      if (link.in_strobe === 1'b1) n_strobe++;
      if (link.skip_strobe === 1'b1) n_skip++;
      if (w_sent === 1'b1) n_sent++;
      if (sk_seen === 1'b1) n_seen++;
   end

   task automatic check(input string name, input logic [23:0] seen,
      input logic [23:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   function automatic logic watched(input int which);
      case (which)
         WATCH_READY: return wd_ready;
         WATCH_VALID: return w_valid;
         WATCH_BUSY: return busy;
         default: return sk_done;
      endcase
   endfunction : watched

   task automatic wait_for(input int which, input logic lvl,
      input string what);
      for (int k = 0; k < 200; k++)
      begin
         if (watched(which) === lvl)
            return;
         @(negedge i_clk);
      end
      failures++;
      $display("wrong value %s expected %b seen %b", what, lvl,
         watched(which));
      finish_test();
   endtask : wait_for

   // caller stands at a falling edge; valid is left high for the next push
   task automatic push(input logic [0:23] w);
      wd_valid = 1'b1;
      wd = w;
      wait_for(WATCH_READY, 1'b1, "word ready");
      @(negedge i_clk);
   endtask : push

   task automatic start_in();
      in_start = 1'b1;
      n_strobe = 0;
      n_sent = 0;
      @(negedge i_clk);
      in_start = 1'b0;
   endtask : start_in

   task automatic get_word(input logic [0:23] exp);
      wait_for(WATCH_VALID, 1'b1, "word valid");
      check("c word", c_word, exp);
      check("data lines", link.input_data_line_n, ~exp);
      check("termination", 24'(link.in_term_n), 24'h0);
      check("wait left", 24'(link.in_wait), 24'h0);
      wait_for(WATCH_BUSY, 1'b0, "idle");
      check("word sent", 24'(n_sent), 24'h1);
   endtask : get_word

   task automatic skip(input logic m, input logic u, input logic s);
      unit_c = u;
      sys_c = s;
      repeat (2) @(negedge i_clk);
      sk_start = 1'b1;
      sk_mode = m;
      n_skip = 0;
      n_seen = 0;
      @(negedge i_clk);
      sk_start = 1'b0;
      wait_for(WATCH_SKIP, 1'b1, "skip done");
      check("skip taken", 24'(sk_taken), 24'(m ? s : u));
      check("skip strobes", 24'(n_skip), 24'h1);
      wait_for(WATCH_BUSY, 1'b0, "idle");
      // the far end reports the strobe one clock after it stands
      @(negedge i_clk);
      check("skip seen", 24'(n_seen), 24'h1);
   endtask : skip

   initial
   begin
      failures = 0;
      checks_done = 0;
      n_strobe = 0;
      n_skip = 0;
      i_reset = 1'b1;
      in_start = 1'b0;
      sk_start = 1'b0;
      sk_mode = 1'b0;
      wd_valid = 1'b0;
      wd = 24'h000000;
      unit_c = 1'b0;
      sys_c = 1'b0;
      repeat (20) @(negedge i_clk);
      i_reset = 1'b0;
      @(negedge i_clk);
      check("term idle", 24'(link.in_term_n), 24'h1);
      check("lines idle", link.input_data_line_n, 24'hFFFFFF);
      for (int k = 0; k < 8; k++)
         skip(k[2], k[1], k[0]);
      // empty buffer: the computer must keep waiting and strobing
      start_in();
      sk_start = 1'b1;
      n_skip = 0;
      @(negedge i_clk);
      sk_start = 1'b0;
      repeat (39) @(negedge i_clk);
      check("refused skip", 24'(n_skip), 24'h0);
      check("still waiting", 24'(busy & link.in_wait), 24'h1);
      check("strobes", 24'(n_strobe >= 4), 24'h1);
      push(24'hFFFFFF);
      wd_valid = 1'b0;
      get_word(24'hFFFFFF);
      check("wait count", 24'(wait_cyc), 24'(n_strobe));
      for (int k = 0; k < 32; k++)
         push(24'hA50000 ^ 24'(k * 24'h010203));
      check("buffer full", 24'(wd_ready), 24'h0);
      @(negedge i_clk);
      wd_valid = 1'b0;
      for (int k = 0; k < 32; k++)
      begin
         start_in();
         get_word(24'hA50000 ^ 24'(k * 24'h010203));
      end
      check("buffer drained", 24'(wd_ready), 24'h1);
      finish_test();
   end
endmodule : parallel_word_input_port_test
`default_nettype wire

//--- verif/word_input_link_assertions.sv
// concurrent checks on the signals of the word input link
`timescale 1ns/1ns
`default_nettype none
module word_input_link_assertions
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // link signals
   input wire logic in_wait,
   input wire logic in_strobe,
   input wire logic in_term_n,
   input wire logic skip_strobe,
   input wire logic external_ready_n,
   input wire logic [0:word_input_pkg::WORD_W-1] input_data_line_n,
   input wire logic unit_resp_n,
   input wire logic system_resp_n
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   sequence s_gap;
      !in_strobe [*7];
   endsequence
   sequence s_term_hold;
      !in_term_n [*8] ##1 in_term_n;
   endsequence

   property p_strobe_period;
      in_strobe |=> s_gap ##1 (in_strobe || !in_term_n);
   endproperty
   a_strobe_period: assert property (p_strobe_period)
      else $error("input strobe spacing wrong");
   property p_first_strobe;
      $rose(in_wait) |-> ##[1:8] (in_strobe || !in_term_n);
   endproperty
   a_first_strobe: assert property (p_first_strobe)
      else $error("no strobe in first computer cycle");
   property p_term_hold;
      $fell(in_term_n) |-> s_term_hold;
   endproperty
   a_term_hold: assert property (p_term_hold)
      else $error("termination length wrong");
   property p_term_ends_wait;
      $fell(in_term_n) |-> !in_wait && $past(in_wait);
   endproperty
   a_term_ends_wait: assert property (p_term_ends_wait)
      else $error("termination outside wait");
   property p_release;
      in_wait && !external_ready_n |-> ##[1:8] !in_term_n;
   endproperty
   a_release: assert property (p_release)
      else $error("wait not released by ready");
   property p_term_cause;
      $fell(in_term_n) |-> !$past(external_ready_n);
   endproperty
   a_term_cause: assert property (p_term_cause)
      else $error("termination without ready");
   property p_skip_single;
      skip_strobe |=> !skip_strobe [*2];
   endproperty
   a_skip_single: assert property (p_skip_single)
      else $error("skip strobe repeated");
   property p_data_hold;
      $fell(in_term_n) |-> $stable(input_data_line_n);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("data lines moved before termination");
endmodule : word_input_link_assertions
`default_nettype wire
